// ==== hdl/patc_ctrl.sv ====
// pa tuning capacitor and gain calibration control registers.
// assumes an analog calibration engine on the same clock that
// takes a reset level and a start pulse and returns a done pulse.
//
// Behaviour
// - request high holds calibration reset; 1->0 starts
// - one request calibrates cap and gain; write-only
// - cap disable picks user cap, else calibrated
// - user cap is 6 bits, 0.3 pF, reset 0
// - cap field reads last calibration result
// - gain disable bit 6 picks user gain
// - gain 4 bits reset 1111, reads calibration result
`timescale 1ns/100ps

module patc_ctrl
  import patc_pkg::*;
(
  input  wire logic        i_clk_sys,   // 250 MHz system clock
  input  wire logic        i_rst_n,     // synchronous reset, active low
  input  wire patc_bus_t   i_bus,       // register port requests
  output logic [7:0]       o_rdata,     // read data, cycle after read
  input  wire patc_res_t   i_res,       // calibration engine results
  output logic             o_cal_rst,   // engine held in reset
  output logic             o_cal_start, // one-cycle start pulse
  output logic             o_cal_busy,  // calibration in progress
  output logic [5:0]       o_pa_cap,    // cap code applied to amplifier
  output logic [3:0]       o_pa_gain,   // gain code applied to amplifier
  output logic [1:0]       o_pa_ipow    // amplifier current setting
);

  patc_state_t st;       // registered state
  patc_state_t next_st;  // next state

  // address decode, shared by writes and reads
  function automatic logic is_addr(input logic [7:0] a, input logic [7:0] r);
    is_addr = (a == r);
  endfunction : is_addr

  logic wr_cap;   // write to the cap register
  logic wr_gain;  // write to the gain register
  logic rd_cap;   // read of the cap register
  logic rd_gain;  // read of the gain register

  assign wr_cap  = i_bus.wr && is_addr(i_bus.addr, PATC_ADDR_CAP);
  assign wr_gain = i_bus.wr && is_addr(i_bus.addr, PATC_ADDR_GAIN);
  assign rd_cap  = i_bus.rd && is_addr(i_bus.addr, PATC_ADDR_CAP);
  assign rd_gain = i_bus.rd && is_addr(i_bus.addr, PATC_ADDR_GAIN);

  // next-state logic for registers and sequencer.
  // the cap register carries three things in one write: the request
  // bit, the cap disable bit and the user cap code. every write to it
  // rewrites all three, so software that only wants to start a run
  // must write the disable bit and user cap it wants to keep as well.
  // the gain register works the same way for its disable bit, the
  // current setting and the user gain code.
  //
  // the sequencer looks at next_st.req rather than st.req, so a write
  // acts on the edge that takes it: a write of 1 enters the hold at
  // once, and a write of 0 out of the hold gives the start pulse on
  // the very next cycle. the trade is a longer path from the bus
  // decode into the state flops, which is short at this clock.
  always_comb begin
    next_st       = st;
    next_st.start = 1'b0;                // start is a single pulse
    next_st.rdata = PATC_RD_ZERO;        // read data stands one cycle only

    // cap register write: request, disable, user cap
    if (wr_cap) begin
      next_st.req      = i_bus.wdata[PATC_CAP_REQ_BIT];
      next_st.cap_dis  = i_bus.wdata[PATC_CAP_DIS_BIT];
      next_st.user_cap = i_bus.wdata[PATC_CAP_MSB:PATC_CAP_LSB];
    end

    // gain register write: disable, current, user gain
    if (wr_gain) begin
      next_st.gain_dis  = i_bus.wdata[PATC_GAIN_DIS_BIT];
      next_st.ipow      = i_bus.wdata[PATC_IPOW_MSB:PATC_IPOW_LSB];
      next_st.user_gain = i_bus.wdata[PATC_GAIN_MSB:PATC_GAIN_LSB];
    end

    // sequencer: a new write of the request always wins over a run
    case (st.fsm)
      PATC_IDLE: begin
        if (next_st.req) begin
          next_st.fsm = PATC_HOLD;
        end
      end
      PATC_HOLD: begin
        // only a software write of 0 releases the hold
        if (!next_st.req) begin
          next_st.fsm   = PATC_RUN;
          next_st.start = 1'b1;
        end
      end
      PATC_RUN: begin
        if (next_st.req) begin
          next_st.fsm = PATC_HOLD;       // re-request aborts the run
        end else if (i_res.done) begin
          // one run yields both results together
          next_st.cal_cap  = i_res.cap;
          next_st.cal_gain = i_res.gain;
          next_st.fsm      = PATC_IDLE;
        end
      end
      default: begin
        next_st.fsm = PATC_IDLE;
      end
    endcase

    // read data: request bit is write-only and reads 0; fields read results
    if (rd_cap) begin
      next_st.rdata = {1'b0, st.cap_dis, st.cal_cap};
    end else if (rd_gain) begin
      next_st.rdata = {1'b0, st.gain_dis, st.ipow, st.cal_gain};
    end
  end

  // state register with synchronous reset
  always_ff @(posedge i_clk_sys) begin
    if (!i_rst_n) begin
      st.fsm       <= PATC_IDLE;
      st.req       <= PATC_RST_REQ;
      st.start     <= 1'b0;
      st.cap_dis   <= PATC_RST_DIS;
      st.user_cap  <= PATC_RST_CAP;
      st.cal_cap   <= PATC_RST_CAP;
      st.gain_dis  <= PATC_RST_DIS;
      st.ipow      <= PATC_RST_IPOW;
      st.user_gain <= PATC_RST_GAIN;
      st.cal_gain  <= PATC_RST_GAIN;
      st.rdata     <= PATC_RD_ZERO;
    end else begin
      st <= next_st;
    end
  end

  // outputs, all taken from flops, a plain select of flops or a compare on the state flops.
  // the engine reset is the stored request bit itself, so it rises on
  // the edge that takes the write of 1 and falls on the one that takes the write of 0.
  // the start pulse and busy flag both come from the sequencer flops,
  // so they never glitch on a bus strobe.
  assign o_rdata     = st.rdata;
  assign o_cal_rst   = st.req;
  assign o_cal_start = st.start;
  assign o_cal_busy  = (st.fsm == PATC_RUN);
  // the select is kept outside the engine so a disable takes effect at once
  assign o_pa_cap    = st.cap_dis  ? st.user_cap  : st.cal_cap;
  assign o_pa_gain   = st.gain_dis ? st.user_gain : st.cal_gain;
  assign o_pa_ipow   = st.ipow;

  // checks on the sequencer and the register map.
  // all of them sample on the system clock and are switched off while
  // reset is low, so the reset values themselves are left to the bench.
  // the checks look only at what this module drives or decodes.
  default clocking cb @(posedge i_clk_sys); endclocking
  default disable iff (!i_rst_n);

  // a write of 0 out of the hold gives one start pulse
  a_start_on_fall: assert property (
    (st.req && wr_cap && !i_bus.wdata[PATC_CAP_REQ_BIT]) |=> (o_cal_start && !o_cal_rst) ##1 !o_cal_start)
    else $error("no single start pulse after request fell");

  // nothing runs while the engine is held in reset
  a_hold_no_start: assert property (
    o_cal_rst |-> !o_cal_start && !o_cal_busy)
    else $error("calibration ran while held in reset");

  // one done stores both results and ends the run
  a_both_results: assert property (
    (o_cal_busy && i_res.done && !next_st.req)
      |=> (st.cal_cap == $past(i_res.cap)) && (st.cal_gain == $past(i_res.gain)) && !o_cal_busy)
    else $error("calibration did not store both results");

  // the request bit is write-only and reads back as 0
  a_req_reads_zero: assert property (
    rd_cap |=> !o_rdata[PATC_CAP_REQ_BIT])
    else $error("request bit read back as one");

  // a write with the cap disable set applies the user cap
  a_cap_select: assert property (
    (wr_cap && i_bus.wdata[PATC_CAP_DIS_BIT]) |=> (o_pa_cap == $past(i_bus.wdata[PATC_CAP_MSB:PATC_CAP_LSB])))
    else $error("applied cap does not follow disable bit");

  // a write with the cap disable clear applies the calibrated cap
  a_cap_cal_sel: assert property (
    (wr_cap && !i_bus.wdata[PATC_CAP_DIS_BIT] && !o_cal_busy) |=> (o_pa_cap == $past(st.cal_cap)))
    else $error("calibrated cap not applied when enabled");

  // the user cap field is stored as written
  a_user_cap_store: assert property (
    wr_cap |=> (st.user_cap == $past(i_bus.wdata[PATC_CAP_MSB:PATC_CAP_LSB])))
    else $error("user cap write not stored");

  // a cap read returns the result, then the data falls back to 0
  a_cap_readback: assert property (
    rd_cap |=> (o_rdata[PATC_CAP_MSB:PATC_CAP_LSB] == $past(st.cal_cap)) ##1 (o_rdata == PATC_RD_ZERO || $past(i_bus.rd)))
    else $error("cap read did not return calibration result");

  // a write with the gain disable set applies the user gain
  a_gain_select: assert property (
    (wr_gain && i_bus.wdata[PATC_GAIN_DIS_BIT]) |=> (o_pa_gain == $past(i_bus.wdata[PATC_GAIN_MSB:PATC_GAIN_LSB])))
    else $error("user gain not applied when disabled");

  // a gain read returns the calibration result
  a_gain_readback: assert property (
    rd_gain |=> (o_rdata[PATC_GAIN_MSB:PATC_GAIN_LSB] == $past(st.cal_gain)))
    else $error("gain read did not return calibration result");

  // a write with the gain disable clear applies the calibrated gain
  a_gain_cal_sel: assert property (
    (wr_gain && !i_bus.wdata[PATC_GAIN_DIS_BIT] && !o_cal_busy) |=> (o_pa_gain == $past(st.cal_gain)))
    else $error("calibrated gain not applied when enabled");

  // the engine reset follows the request bit written
  a_rst_follows_req: assert property (
    wr_cap |=> (o_cal_rst == $past(i_bus.wdata[PATC_CAP_REQ_BIT])))
    else $error("engine reset does not follow request bit");

  // a write of 0 with no request pending starts nothing
  a_zero_no_start: assert property (
    (!st.req && wr_cap && !i_bus.wdata[PATC_CAP_REQ_BIT]) |=> !o_cal_start)
    else $error("start pulse without a prior request");

  // the start pulse lasts one cycle only
  a_start_single: assert property (
    o_cal_start |=> !o_cal_start)
    else $error("start pulse longer than one cycle");

  // the start pulse always comes with the busy flag
  a_start_busy: assert property (
    o_cal_start |-> o_cal_busy)
    else $error("start pulse without busy");

  // a fresh request during a run aborts back to the hold
  a_abort_run: assert property (
    (o_cal_busy && wr_cap && i_bus.wdata[PATC_CAP_REQ_BIT]) |=> (o_cal_rst && !o_cal_busy))
    else $error("re-request did not abort the run");

  // results never change outside a run
  a_done_ignored: assert property (
    !o_cal_busy |=> (st.cal_cap == $past(st.cal_cap)) && (st.cal_gain == $past(st.cal_gain)))
    else $error("calibration result changed outside a run");

  // the cap disable bit reads back as written
  a_cap_dis_read: assert property (
    rd_cap |=> (o_rdata[PATC_CAP_DIS_BIT] == $past(st.cap_dis)))
    else $error("cap disable bit read back wrong");

  // the gain disable bit reads back as written
  a_gain_dis_read: assert property (
    rd_gain |=> (o_rdata[PATC_GAIN_DIS_BIT] == $past(st.gain_dis)))
    else $error("gain disable bit read back wrong");

  // the gain register top bit reads as 0
  a_gain_msb_zero: assert property (
    rd_gain |=> !o_rdata[7])
    else $error("gain register top bit read back as one");

  // the user gain field is stored as written
  a_user_gain_store: assert property (
    wr_gain |=> (st.user_gain == $past(i_bus.wdata[PATC_GAIN_MSB:PATC_GAIN_LSB])))
    else $error("user gain write not stored");

  // read data stand only in the cycle after a mapped read
  a_rdata_idle: assert property (
    !(rd_cap || rd_gain) |=> (o_rdata == PATC_RD_ZERO))
    else $error("read data outside a read cycle");

endmodule : patc_ctrl

// ==== include/patc_pkg.sv ====
// package for the pa tuning calibration control block.
// assumes an 8-bit register port on the single system clock.
package patc_pkg;

  // register addresses on the control port
  localparam logic [7:0] PATC_ADDR_CAP  = 8'h59; // tuning cap calibration
  localparam logic [7:0] PATC_ADDR_GAIN = 8'h5A; // output gain calibration

  // capacitor register field positions
  localparam int PATC_CAP_REQ_BIT = 7;  // calibration request, write-only
  localparam int PATC_CAP_DIS_BIT = 6;  // cap calibration disable
  localparam int PATC_CAP_LSB     = 0;  // user cap field low bit
  localparam int PATC_CAP_MSB     = 5;  // user cap field high bit

  // gain register field positions
  localparam int PATC_GAIN_DIS_BIT = 6; // gain calibration disable
  localparam int PATC_IPOW_LSB     = 4; // amplifier current low bit
  localparam int PATC_IPOW_MSB     = 5; // amplifier current high bit
  localparam int PATC_GAIN_LSB     = 0; // gain field low bit
  localparam int PATC_GAIN_MSB     = 3; // gain field high bit

  // reset values
  localparam logic       PATC_RST_REQ  = 1'h0;
  localparam logic       PATC_RST_DIS  = 1'h0;
  localparam logic [5:0] PATC_RST_CAP  = 6'h00;
  localparam logic [1:0] PATC_RST_IPOW = 2'h0;
  localparam logic [3:0] PATC_RST_GAIN = 4'hF;
  localparam logic [7:0] PATC_RD_ZERO  = 8'h00;

  // calibration sequencer states
  typedef enum logic [1:0] {
    PATC_IDLE,   // no calibration in progress
    PATC_HOLD,   // engine held in reset by the request bit
    PATC_RUN     // engine running, waiting for its done
  } patc_fsm_t;

  // software register port
  typedef struct packed {
    logic [7:0] addr;  // register address
    logic [7:0] wdata; // write data
    logic       wr;    // one-cycle write strobe
    logic       rd;    // one-cycle read strobe
  } patc_bus_t;

  // results from the calibration engine
  typedef struct packed {
    logic       done;  // one-cycle pulse when results are valid
    logic [5:0] cap;   // calibrated tuning cap code
    logic [3:0] gain;  // calibrated gain code
  } patc_res_t;

  // whole state of the control module
  typedef struct packed {
    patc_fsm_t  fsm;       // sequencer state
    logic       req;       // stored request bit
    logic       start;     // start pulse to the engine
    logic       cap_dis;   // use user cap when set
    logic [5:0] user_cap;  // software cap setting
    logic [5:0] cal_cap;   // last calibrated cap
    logic       gain_dis;  // use user gain when set
    logic [1:0] ipow;      // amplifier current setting
    logic [3:0] user_gain; // software gain setting
    logic [3:0] cal_gain;  // last calibrated gain
    logic [7:0] rdata;     // read data, valid one cycle
  } patc_state_t;

endpackage : patc_pkg

// ==== verif/patc_ctrl_bench.sv ====
// self-checking bench for the pa tuning calibration control registers.
// assumes the bench stands in for both the register master and the cal engine.
`timescale 1ns/100ps

module patc_ctrl_bench;
  import patc_pkg::*;

  logic        i_clk_sys = 1'b0;  // 250 MHz system clock
  logic        i_rst_n   = 1'b0;  // synchronous reset, active low
  patc_bus_t   bus       = '0;    // register port requests
  patc_res_t   res       = '0;    // engine results
  logic [7:0]  rdata;             // read data from the block
  logic        cal_rst;           // engine reset level
  logic        cal_start;         // engine start pulse
  logic        cal_busy;          // calibration in progress
  logic [5:0]  pa_cap;            // applied cap code
  logic [3:0]  pa_gain;           // applied gain code
  logic [1:0]  pa_ipow;           // applied current setting
  logic [7:0]  rd_val;            // last value read back
  int          fails   = 0;       // mismatches seen
  int          n_tests = 0;       // comparisons made

  // half period of 2 ns gives the 4 ns system clock
  always #2 i_clk_sys = ~i_clk_sys;

  patc_ctrl dut (
    .i_clk_sys   (i_clk_sys),
    .i_rst_n     (i_rst_n),
    .i_bus       (bus),
    .o_rdata     (rdata),
    .i_res       (res),
    .o_cal_rst   (cal_rst),
    .o_cal_start (cal_start),
    .o_cal_busy  (cal_busy),
    .o_pa_cap    (pa_cap),
    .o_pa_gain   (pa_gain),
    .o_pa_ipow   (pa_ipow)
  );

  // one compare for every 8-bit result; narrow values are zero extended
  task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
    n_tests++;
    if (got !== exp) begin
      fails++;
      $display("[ERR] %s expected %h seen %h", name, exp, got);
    end
  endtask : chk

  // one-cycle write; returns just after the edge that took it
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge i_clk_sys);
    bus.wr <= 1'b0;
    #1;
  endtask : wr

  // one-cycle read; data only stand in the cycle after the strobe
  task automatic rd(input logic [7:0] a);
    @(posedge i_clk_sys);
    bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge i_clk_sys);
    bus.rd <= 1'b0;
    #1;
    rd_val = rdata;
  endtask : rd

  // reset values at the outputs and through both registers
  task automatic t_reset;
    chk("pa_cap", 8'h00, {2'h0, pa_cap});
    chk("pa_gain", 8'h0F, {4'h0, pa_gain});
    chk("cal_rst", 8'h00, {7'h00, cal_rst});
    rd(PATC_ADDR_CAP);  chk("cap_reg", 8'h00, rd_val);
    rd(PATC_ADDR_GAIN); chk("gain_reg", 8'h0F, rd_val);
    $display("test reset done");
  endtask : t_reset

  // hold, release, then one done that carries both results
  task automatic t_cal;
    wr(PATC_ADDR_CAP, 8'h80);
    chk("cal_rst_hold", 8'h01, {7'h00, cal_rst});
    repeat (3) @(posedge i_clk_sys);
    #1 chk("no_start_held", 8'h00, {7'h00, cal_start});
    rd(PATC_ADDR_CAP);  chk("req_wo", 8'h00, rd_val);
    wr(PATC_ADDR_CAP, 8'h00);
    chk("start_edge", 8'h03, {6'h00, cal_start, cal_busy});
    chk("rst_off", 8'h00, {7'h00, cal_rst});
    @(posedge i_clk_sys);
    res <= '{done: 1'b1, cap: 6'h2A, gain: 4'h3};
    @(posedge i_clk_sys);
    res <= '{done: 1'b0, cap: 6'h15, gain: 4'hC};        // stale values change after done
    #1 chk("busy_end", 8'h00, {7'h00, cal_busy});
    chk("pa_cap_cal", 8'h2A, {2'h0, pa_cap});
    chk("pa_gain_cal", 8'h03, {4'h0, pa_gain});
    rd(PATC_ADDR_CAP);  chk("cap_result", 8'h2A, rd_val);
    rd(PATC_ADDR_GAIN); chk("gain_result", 8'h03, rd_val);
    $display("test calibration done");
  endtask : t_cal

  // disable bits pick the user values, reads keep the results
  task automatic t_dis;
    wr(PATC_ADDR_CAP, 8'h45);
    chk("pa_cap_user", 8'h05, {2'h0, pa_cap});
    rd(PATC_ADDR_CAP);  chk("cap_rd_dis", 8'h6A, rd_val);
    wr(PATC_ADDR_GAIN, 8'h7C);
    chk("pa_gain_user", 8'h0C, {4'h0, pa_gain});
    chk("pa_ipow", 8'h03, {6'h00, pa_ipow});
    rd(PATC_ADDR_GAIN); chk("gain_rd_dis", 8'h73, rd_val);
    wr(PATC_ADDR_CAP, 8'h05);
    chk("pa_cap_back", 8'h2A, {2'h0, pa_cap});
    $display("test disable done");
  endtask : t_dis

  // done outside a run and unmapped accesses change nothing
  task automatic t_stray;
    @(posedge i_clk_sys);
    res <= '{done: 1'b1, cap: 6'h11, gain: 4'h9};
    @(posedge i_clk_sys);
    res.done <= 1'b0;
    wr(8'h5B, 8'hFF);
    rd(8'h5B);          chk("unmapped", 8'h00, rd_val);
    rd(PATC_ADDR_CAP);  chk("cap_kept", 8'h2A, rd_val);
    rd(PATC_ADDR_GAIN); chk("gain_kept", 8'h73, rd_val);
    $display("test stray done");
  endtask : t_stray

  // enabled gain, a re-request that aborts a run, and a lone write of 0
  task automatic t_abort;
    wr(PATC_ADDR_GAIN, 8'h00);
    chk("pa_gain_back", 8'h03, {4'h0, pa_gain});
    wr(PATC_ADDR_CAP, 8'h80);
    wr(PATC_ADDR_CAP, 8'h00);
    chk("run_busy", 8'h01, {7'h00, cal_busy});
    wr(PATC_ADDR_CAP, 8'h80);
    chk("abort", 8'h02, {6'h00, cal_rst, cal_busy});
    wr(PATC_ADDR_CAP, 8'h00);
    @(posedge i_clk_sys);
    res <= '{done: 1'b1, cap: 6'h15, gain: 4'hC};
    @(posedge i_clk_sys);
    res.done <= 1'b0;
    #1 chk("pa_cap_new", 8'h15, {2'h0, pa_cap});
    chk("pa_gain_new", 8'h0C, {4'h0, pa_gain});
    rd(PATC_ADDR_GAIN); chk("gain_new", 8'h0C, rd_val);
    wr(PATC_ADDR_CAP, 8'h00);
    chk("no_start", 8'h00, {6'h00, cal_start, cal_busy});
    $display("test abort done");
  endtask : t_abort

  // verdict, printed once from here only
  task automatic tally_and_finish;
    $display("comparisons %0d mismatches %0d", n_tests, fails);
    if (fails == 0 && n_tests > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : tally_and_finish

  // main sequence after four cycles of reset
  initial begin
    repeat (4) @(posedge i_clk_sys);
    i_rst_n <= 1'b1;
    #1;
    t_reset();
    t_cal();
    t_dis();
    t_stray();
    t_abort();
    tally_and_finish();
  end

  // the tests need well under 200 cycles; allow ample margin
  initial begin
    #20000;
    fails++;
    tally_and_finish();
  end

endmodule : patc_ctrl_bench
